// *** pkg/cmpt_pkg.sv ***
// Summary of operation
// RULE_01: ascending test writes own address upward
// RULE_02: ascending check reads high limit downward
// RULE_03: address compare failure halts, holds address/data
// RULE_04: descending test writes down, verifies up
// RULE_05: descending test never touches below 100
// RULE_06: no-dual: ones field, zero test location
// RULE_07: scan field each step, advance pointer
// RULE_08: second phase uses zeros background, ones test
// RULE_09: every data bit tested both ways
// RULE_10: each pattern: fill zone, read, compare, advance
// RULE_11: pattern mismatch reports, sequence continues
// RULE_12: noise part one: ones where bits differ
// RULE_13: rescan read, complement, read, complement
// RULE_14: first read mismatch flagged as error
// RULE_15: part one end enters part two itself
// RULE_16: noise part two uses inverted placement
// RULE_17: end of pass reports, restarts unless halting
// RULE_18: limits are inputs, one access at time
// RULE_19: done indication, sticky error until restart
package cmpt_pkg;

  // ---------------------------------------------------------------
  // widths and fixed values
  // ---------------------------------------------------------------
  localparam int AW = 16; // address width
  localparam int DW = 16; // data word width
  localparam logic [AW-1:0] VEC_FLOOR = 16'h0064; // lowest address for descending test (100)
  localparam logic [DW-1:0] ONES = 16'hffff; // all-ones word
  localparam logic [DW-1:0] ZEROS = 16'h0000; // all-zeros word
  localparam int NOISE_BIT_A = 3; // first address bit of noise split
  localparam int NOISE_BIT_B = 9; // second address bit of noise split
  localparam logic [2:0] NUM_PAT = 3'h6; // fixed patterns per pass
  localparam logic [AW-1:0] ADDR_RST = 16'h0000; // reset value of pointers
  localparam logic [DW-1:0] DATA_RST = 16'h0000; // reset value of data regs

  // ---------------------------------------------------------------
  // algorithm select
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ALG_UP = 3'h0,
    ALG_DOWN = 3'h1,
    ALG_PATTERN = 3'h3,
    ALG_NODUAL = 3'h2,
    ALG_NOISE = 3'h6
  } cmpt_alg_e;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FILL = 4'h1,
    ST_CHECK = 4'h3,
    ST_ND_WR = 4'h2,
    ST_ND_RD = 4'h6,
    ST_ND_RST = 4'h7,
    ST_ND_SCAN = 4'h5,
    ST_NZ_R1 = 4'h4,
    ST_NZ_W1 = 4'hc,
    ST_NZ_R2 = 4'hd,
    ST_NZ_W2 = 4'hf,
    ST_HALT = 4'he,
    ST_DONE = 4'ha
  } cmpt_state_e;

  // fixed data pattern table
  function automatic logic [DW-1:0] cmpt_pat(input logic [2:0] idx);
    case (idx)
      3'h0: cmpt_pat = 16'h0000;
      3'h1: cmpt_pat = 16'hffff;
      3'h2: cmpt_pat = 16'haaaa;
      3'h3: cmpt_pat = 16'h5555;
      3'h4: cmpt_pat = 16'hcccc;
      3'h5: cmpt_pat = 16'h3333;
      default: cmpt_pat = 16'h0000;
    endcase
  endfunction : cmpt_pat

endpackage : cmpt_pkg

// *** hdl/cmpt_mem_port.sv ***
`timescale 1ns/100ps
module cmpt_mem_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sequencer side
  input wire logic go_i,
  input wire logic we_i,
  input wire logic [cmpt_pkg::AW-1:0] addr_i,
  input wire logic [cmpt_pkg::DW-1:0] wdata_i,
  output logic ready_o,
  output logic done_o,
  output logic [cmpt_pkg::DW-1:0] rdata_o,
  // memory side
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [cmpt_pkg::AW-1:0] mem_addr_o,
  output logic [cmpt_pkg::DW-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [cmpt_pkg::DW-1:0] mem_rdata_i
);
  import cmpt_pkg::*;

  // ---------------------------------------------------------------
  // single outstanding access
  // ---------------------------------------------------------------
  // a new access is accepted only while no request is open
  assign ready_o = ~mem_req_o; // [RULE_18]

  // request stays up until the memory acknowledges
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= ADDR_RST;
      mem_wdata_o <= DATA_RST;
    end else if (go_i && !mem_req_o) begin
      mem_req_o <= 1'b1; // [RULE_18]
      mem_we_o <= we_i;
      mem_addr_o <= addr_i;
      mem_wdata_o <= wdata_i;
    end else if (mem_ack_i && mem_req_o) begin
      mem_req_o <= 1'b0;
    end
  end

  // completion pulse and captured read data
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      rdata_o <= DATA_RST;
    end else begin
      done_o <= mem_ack_i & mem_req_o;
      if (mem_ack_i && mem_req_o && !mem_we_o) begin
        rdata_o <= mem_rdata_i;
      end
    end
  end

endmodule : cmpt_mem_port

// *** hdl/cmpt_top.sv ***
`timescale 1ns/100ps
module cmpt_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // run control and limits
  input wire logic start_i,
  input wire cmpt_pkg::cmpt_alg_e alg_i,
  input wire logic [cmpt_pkg::AW-1:0] low_lim_i,
  input wire logic [cmpt_pkg::AW-1:0] high_lim_i,
  input wire logic halt_at_end_i,
  // memory under test
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [cmpt_pkg::AW-1:0] mem_addr_o,
  output logic [cmpt_pkg::DW-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [cmpt_pkg::DW-1:0] mem_rdata_i,
  // status and error report
  output logic busy_o,
  output logic done_o,
  output logic halted_o,
  output logic err_o,
  output logic err_evt_o,
  output logic [cmpt_pkg::AW-1:0] err_addr_o,
  output logic [cmpt_pkg::DW-1:0] err_data_o,
  output logic [cmpt_pkg::DW-1:0] err_exp_o,
  output logic pass_end_o,
  output logic part_o
);
  import cmpt_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // background word of a location for the running algorithm
  function automatic logic [DW-1:0] bg_word(
    input cmpt_alg_e alg_f,
    input logic ph_f,
    input logic [2:0] pi_f,
    input logic [AW-1:0] ad_f
  );
    logic split;
    split = ad_f[NOISE_BIT_A] ^ ad_f[NOISE_BIT_B];
    case (alg_f)
      ALG_UP, ALG_DOWN: bg_word = ad_f; // [RULE_01] [RULE_04]
      ALG_NODUAL: bg_word = ph_f ? ZEROS : ONES; // [RULE_06] [RULE_08]
      ALG_PATTERN: bg_word = cmpt_pat(pi_f); // [RULE_10]
      ALG_NOISE: bg_word = (split ^ ph_f) ? ONES : ZEROS; // [RULE_12] [RULE_16]
      default: bg_word = ZEROS;
    endcase
  endfunction : bg_word

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cmpt_state_e state; // sequencer state
  cmpt_state_e next_state; // next sequencer state
  cmpt_alg_e alg; // algorithm of this run
  logic [AW-1:0] lo; // effective low limit
  logic [AW-1:0] hi; // high limit
  logic halt_end; // stop after a pass
  logic [AW-1:0] a; // scan pointer
  logic [AW-1:0] next_a;
  logic [AW-1:0] t; // no-dual test pointer
  logic [AW-1:0] next_t;
  logic phase; // phase or part flag
  logic next_phase;
  logic [2:0] pidx; // pattern index
  logic [2:0] next_pidx;
  logic next_pass_end; // pass finished this step
  logic issued; // access outstanding
  logic stale; // outstanding access from aborted run

  // ---------------------------------------------------------------
  // access port
  // ---------------------------------------------------------------
  logic acc_ready; // port can take an access
  logic acc_done; // access finished
  logic [DW-1:0] acc_rdata; // data read back

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire fill_down = (alg == ALG_DOWN); // [RULE_04]
  wire check_down = (alg == ALG_UP); // [RULE_02]
  wire cur_down = (state == ST_FILL) ? fill_down :
                  (state == ST_CHECK) ? check_down : 1'b0;
  wire on_test = (state == ST_ND_WR) || (state == ST_ND_RD) || (state == ST_ND_RST);
  wire [AW-1:0] acc_addr = on_test ? t : a;
  wire invert = (state == ST_ND_WR) || (state == ST_ND_RD) ||
                (state == ST_NZ_W1) || (state == ST_NZ_R2);
  wire [DW-1:0] bg = bg_word(alg, phase, pidx, acc_addr);
  wire [DW-1:0] expd = invert ? ~bg : bg; // [RULE_09] [RULE_13]
  wire is_write = (state == ST_FILL) || (state == ST_ND_WR) || (state == ST_ND_RST) ||
                  (state == ST_NZ_W1) || (state == ST_NZ_W2);
  wire active = (state != ST_IDLE) && (state != ST_HALT) && (state != ST_DONE);
  wire go = active & acc_ready & ~issued & ~stale; // [RULE_18]
  wire step = acc_done & ~stale & active;
  // the second noise read only rescans the complemented word and is not judged
  wire mism = step & ~is_write & (state != ST_NZ_R2) & (acc_rdata != expd); // [RULE_14]
  wire fatal = mism & ((alg == ALG_UP) || (alg == ALG_DOWN)); // [RULE_03]
  wire at_end = cur_down ? (a == lo) : (a == hi);
  wire [AW-1:0] a_inc = a + 16'h0001;
  wire [AW-1:0] a_dec = a - 16'h0001;
  wire [AW-1:0] a_nxt = cur_down ? a_dec : a_inc;
  wire last_pat = (pidx == NUM_PAT - 3'h1);
  // limits of a new run; descending test stays above vector area
  wire [AW-1:0] lo_start = ((alg_i == ALG_DOWN) && (low_lim_i < VEC_FLOOR)) ?
                           VEC_FLOOR : low_lim_i; // [RULE_05]
  wire run_empty = (lo_start > high_lim_i);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // one step is taken per completed access
  always_comb begin
    next_state = state;
    next_a = a;
    next_t = t;
    next_phase = phase;
    next_pidx = pidx;
    next_pass_end = 1'b0;
    if (step) begin
      case (state)
        ST_FILL: begin
          if (!at_end) begin
            next_a = a_nxt; // [RULE_01] [RULE_04]
          end else if (alg == ALG_NODUAL) begin
            next_state = ST_ND_WR; // [RULE_06]
            next_t = lo;
          end else if (alg == ALG_NOISE) begin
            next_state = ST_NZ_R1; // [RULE_13]
            next_a = lo;
          end else begin
            next_state = ST_CHECK; // [RULE_02] [RULE_04]
            next_a = check_down ? hi : lo;
          end
        end
        ST_CHECK: begin
          if (fatal) begin
            next_state = ST_HALT; // [RULE_03]
          end else if (!at_end) begin
            next_a = a_nxt; // [RULE_02] [RULE_11]
          end else if ((alg == ALG_PATTERN) && !last_pat) begin
            next_state = ST_FILL; // [RULE_10]
            next_pidx = pidx + 3'h1;
            next_a = lo;
          end else begin
            next_pass_end = 1'b1;
          end
        end
        ST_ND_WR: begin
          next_state = ST_ND_RD; // [RULE_06]
        end
        ST_ND_RD: begin
          next_state = ST_ND_RST;
        end
        ST_ND_RST: begin
          next_state = ST_ND_SCAN; // [RULE_07]
          next_a = lo;
        end
        ST_ND_SCAN: begin
          if (!at_end) begin
            next_a = a_inc; // [RULE_07]
          end else if (t != hi) begin
            next_state = ST_ND_WR; // [RULE_07]
            next_t = t + 16'h0001;
          end else if (!phase) begin
            next_state = ST_FILL; // [RULE_08]
            next_phase = 1'b1;
            next_a = lo;
          end else begin
            next_pass_end = 1'b1;
          end
        end
        ST_NZ_R1: begin
          next_state = ST_NZ_W1; // [RULE_13]
        end
        ST_NZ_W1: begin
          next_state = ST_NZ_R2; // [RULE_13]
        end
        ST_NZ_R2: begin
          next_state = ST_NZ_W2; // [RULE_13]
        end
        ST_NZ_W2: begin
          if (!at_end) begin
            next_state = ST_NZ_R1; // [RULE_13]
            next_a = a_inc;
          end else if (!phase) begin
            next_state = ST_FILL; // [RULE_15] [RULE_16]
            next_phase = 1'b1;
            next_a = lo;
          end else begin
            next_pass_end = 1'b1;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
      // a finished pass either stops or starts over
      if (next_pass_end) begin
        next_phase = 1'b0; // [RULE_17]
        next_pidx = 3'h0;
        next_a = fill_down ? hi : lo;
        next_state = halt_end ? ST_DONE : ST_FILL; // [RULE_17]
      end
    end
  end

  // ---------------------------------------------------------------
  // sequencer registers
  // ---------------------------------------------------------------
  // a start reloads the limits and begins at the first fill, or goes straight to done when the zone is empty
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      alg <= ALG_UP;
      lo <= ADDR_RST;
      hi <= ADDR_RST;
      halt_end <= 1'b0;
      a <= ADDR_RST;
      t <= ADDR_RST;
      phase <= 1'b0;
      pidx <= 3'h0;
    end else if (start_i) begin
      state <= run_empty ? ST_DONE : ST_FILL; // [RULE_18]
      alg <= alg_i;
      lo <= lo_start; // [RULE_05] [RULE_18]
      hi <= high_lim_i;
      halt_end <= halt_at_end_i;
      a <= (alg_i == ALG_DOWN) ? high_lim_i : lo_start; // [RULE_01] [RULE_04]
      t <= lo_start;
      phase <= 1'b0;
      pidx <= 3'h0;
    end else begin
      state <= next_state;
      a <= next_a;
      t <= next_t;
      phase <= next_phase;
      pidx <= next_pidx;
    end
  end

  // ---------------------------------------------------------------
  // access bookkeeping
  // ---------------------------------------------------------------
  // an access still open when a run restarts is drained, not judged
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      issued <= 1'b0;
      stale <= 1'b0;
    end else if (start_i) begin
      issued <= 1'b0;
      stale <= (~acc_ready & ~acc_done) | go;
    end else begin
      issued <= (issued | go) & ~acc_done; // [RULE_18]
      stale <= stale & ~acc_done;
    end
  end

  // ---------------------------------------------------------------
  // error report
  // ---------------------------------------------------------------
  // sticky flag: a new error wins over the clear of a new run
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_o <= 1'b0;
      err_evt_o <= 1'b0;
      err_addr_o <= ADDR_RST;
      err_data_o <= DATA_RST;
      err_exp_o <= DATA_RST;
    end else begin
      err_o <= (err_o & ~start_i) | mism; // [RULE_19]
      err_evt_o <= mism; // [RULE_11] [RULE_14]
      if (mism) begin
        err_addr_o <= acc_addr; // [RULE_03] [RULE_11]
        err_data_o <= acc_rdata;
        err_exp_o <= expd;
      end
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  // pass end pulse and done level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pass_end_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      pass_end_o <= next_pass_end & ~start_i; // [RULE_17]
      done_o <= (next_state == ST_DONE) & ~start_i; // [RULE_19]
    end
  end

  assign busy_o = active;
  assign halted_o = (state == ST_HALT); // [RULE_03]
  assign part_o = phase;

  // ---------------------------------------------------------------
  // memory access port
  // ---------------------------------------------------------------
  cmpt_mem_port u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .go_i(go),
    .we_i(is_write),
    .addr_i(acc_addr),
    .wdata_i(expd),
    .ready_o(acc_ready),
    .done_o(acc_done),
    .rdata_o(acc_rdata),
    .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i)
  );

endmodule : cmpt_top

// *** dv/cmpt_mem_model.sv ***
`timescale 1ns/100ps
module cmpt_mem_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // access from tester
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic ack_o,
  output logic [15:0] rdata_o,
  // speed and fault control
  input wire logic [1:0] lat_i,
  input wire logic flip_en_i,
  input wire logic [15:0] flip_addr_i
);
  logic [15:0] mem [0:65535]; // word store
  logic [1:0] cnt; // wait cycles spent on current access
  // one ack per access after lat_i waits; faulty word reads with bit 0 flipped
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt <= 2'h0;
      rdata_o <= 16'h0000;
    end else begin
      ack_o <= 1'b0;
      if (req_i && !ack_o && cnt == lat_i) begin
        ack_o <= 1'b1;
        cnt <= 2'h0;
        if (we_i) mem[addr_i] <= wdata_i;
        else rdata_o <= mem[addr_i] ^ {15'h0000, flip_en_i && addr_i == flip_addr_i};
      end else begin
        if (req_i && !ack_o) cnt <= cnt + 2'h1;
        rdata_o <= ~rdata_o; // data lines not valid: keep them moving
      end
    end
  end
endmodule : cmpt_mem_model

// *** dv/cmpt_chk.sv ***
`timescale 1ns/100ps
module cmpt_chk
  import cmpt_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // run control
  input wire logic start_i,
  input wire cmpt_pkg::cmpt_alg_e alg_i,
  input wire logic [cmpt_pkg::AW-1:0] low_lim_i,
  input wire logic [cmpt_pkg::AW-1:0] high_lim_i,
  // memory side
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [cmpt_pkg::AW-1:0] mem_addr_o,
  input wire logic [cmpt_pkg::DW-1:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [cmpt_pkg::DW-1:0] mem_rdata_i,
  // status
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic halted_o,
  input wire logic err_o,
  input wire logic err_evt_o,
  input wire logic [cmpt_pkg::AW-1:0] err_addr_o,
  input wire logic [cmpt_pkg::DW-1:0] err_data_o,
  input wire logic pass_end_o
);
  logic [AW-1:0] lo_q; // zone bottom of current run
  logic [AW-1:0] hi_q; // zone top of current run
  // latch the zone at start, with the vector floor for the descending test
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lo_q <= ADDR_RST;
      hi_q <= ADDR_RST;
    end else if (start_i) begin
      lo_q <= (alg_i == ALG_DOWN && low_lim_i < VEC_FLOOR) ? VEC_FLOOR : low_lim_i;
      hi_q <= high_lim_i;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o)
    && $stable(mem_wdata_o)) else $error("request changed before ack");
  a_req_gap: assert property (mem_req_o && mem_ack_i |=> !mem_req_o ##1 !mem_req_o)
    else $error("access gap too short");
  a_addr_zone: assert property ($rose(mem_req_o) |-> mem_addr_o >= lo_q && mem_addr_o <= hi_q)
    else $error("access outside zone");
  a_halt_quiet: assert property (halted_o |-> !mem_req_o && !busy_o) else $error("access while halted");
  a_halt_evt: assert property ($rose(halted_o) |-> err_evt_o) else $error("halt without error");
  a_evt_read: assert property (err_evt_o |-> $past(mem_ack_i, 2) && !$past(mem_we_o, 2))
    else $error("error not after read");
  a_err_capture: assert property (err_evt_o |-> err_addr_o == $past(mem_addr_o, 2)
    && err_data_o == $past(mem_rdata_i, 2)) else $error("error report wrong");
  a_err_sticky: assert property ((err_o || err_evt_o) && !start_i |=> err_o) else $error("error flag lost");
  a_start_clear: assert property (start_i |=> err_o == err_evt_o) else $error("start kept error");
  a_done_quiet: assert property (done_o |-> !busy_o && !mem_req_o) else $error("activity when done");
  c_halt: cover property ($rose(halted_o));
  c_pass: cover property (pass_end_o && !done_o);
  c_evt: cover property (err_evt_o && !halted_o);
endmodule : cmpt_chk

// *** dv/tb_core_memory_pattern_tester.sv ***
`timescale 1ns/100ps
module tb_core_memory_pattern_tester;
  import cmpt_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, halt_at_end_i = 1'b0;
  cmpt_alg_e alg_i = ALG_UP;
  logic [15:0] low_lim_i = 16'h0000, high_lim_i = 16'h0000, flip_addr = 16'h0000;
  logic [1:0] lat = 2'h0; // memory wait cycles
  logic flip_en = 1'b0; // memory fault on
  logic mem_req_o, mem_we_o, mem_ack_i, busy_o, done_o, halted_o, err_o, err_evt_o, pass_end_o, part_o;
  logic [15:0] mem_addr_o, mem_wdata_o, mem_rdata_i, err_addr_o, err_data_o, err_exp_o;
  int error_cnt = 0, samples_checked = 0, evt_n = 0, pend_n = 0, part_n = 0;
  logic [32:0] exp_q[$], log_q[$]; // {we, addr, data}
  always #25 clk_i = ~clk_i;
  cmpt_top u_dut (.clk_i, .rst_i, .start_i, .alg_i, .low_lim_i, .high_lim_i, .halt_at_end_i, .mem_req_o,
    .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .busy_o, .done_o, .halted_o, .err_o,
    .err_evt_o, .err_addr_o, .err_data_o, .err_exp_o, .pass_end_o, .part_o);
  cmpt_mem_model u_mem (.clk_i, .rst_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i), .lat_i(lat), .flip_en_i(flip_en),
    .flip_addr_i(flip_addr));
  // record every completed access and the event pulses
  always @(posedge clk_i) begin
    if (mem_req_o && mem_ack_i) log_q.push_back({mem_we_o, mem_addr_o, mem_we_o ? mem_wdata_o : mem_rdata_i});
    if (err_evt_o === 1'b1) evt_n++;
    if (pass_end_o === 1'b1) pend_n++;
    if (mem_req_o && mem_ack_i && part_o === 1'b1) part_n++; // accesses made in the second part
  end
  // ---------------------------------------------------------------
  // compare and drive helpers
  // ---------------------------------------------------------------
  task automatic chk_bit(string n, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(string n, logic [32:0] e, logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic chk_log();
    chk_word("access count", 33'(exp_q.size()), 33'(log_q.size()));
    foreach (exp_q[i]) if (i < log_q.size()) chk_word("access", exp_q[i], log_q[i]);
  endtask : chk_log
  task automatic put(logic w, int a, logic [15:0] d);
    exp_q.push_back({w, 16'(a), d});
  endtask : put
  // expected access list, including the fault of the memory model when it is on
  task automatic build(cmpt_alg_e g, int lo, int hi);
    logic [15:0] pats [6] = '{16'h0000, 16'hffff, 16'haaaa, 16'h5555, 16'hcccc, 16'h3333};
    logic [15:0] e;
    exp_q.delete();
    if (g == ALG_DOWN && lo < 100) lo = 100;
    for (int p = 0; p < 6; p++) begin
      e = (p == 0) ? 16'hffff : 16'h0000; // no-dual background
      for (int a = lo; a <= hi && g != ALG_UP && g != ALG_DOWN; a++) put(1, a, (g == ALG_PATTERN) ? pats[p] :
        (g == ALG_NOISE) ? {16{a[3] ^ a[9] ^ p[0]}} : e);
      for (int t = lo; t <= hi && g == ALG_NODUAL; t++) begin
        put(1, t, ~e); put(0, t, ~e); put(1, t, e);
        for (int a = lo; a <= hi; a++) put(0, a, e);
      end
      for (int a = lo; a <= hi && g == ALG_PATTERN; a++) put(0, a, pats[p]);
      for (int a = lo; a <= hi && g == ALG_NOISE; a++) begin
        e = {16{a[3] ^ a[9] ^ p[0]}};
        put(0, a, e); put(1, a, ~e); put(0, a, ~e); put(1, a, e);
      end
      if (g == ALG_PATTERN || (p == 0 && (g == ALG_NODUAL || g == ALG_NOISE))) continue;
      for (int a = hi; a >= lo && g == ALG_UP; a--) put(1, lo + hi - a, 16'(lo + hi - a));
      for (int a = hi; a >= lo && g == ALG_DOWN; a--) put(1, a, 16'(a));
      for (int a = lo; a <= hi && g != ALG_NODUAL && g != ALG_PATTERN && g != ALG_NOISE; a++)
        put(0, (g == ALG_UP) ? hi + lo - a : a, 16'((g == ALG_UP) ? hi + lo - a : a));
      break;
    end
    // a faulty word reads back with bit 0 flipped
    foreach (exp_q[i]) if (flip_en && !exp_q[i][32] && exp_q[i][31:16] == flip_addr) exp_q[i][0] = ~exp_q[i][0];
  endtask : build
  task automatic run(cmpt_alg_e g, logic [15:0] lo, logic [15:0] hi, logic h);
    log_q.delete();
    evt_n = 0;
    pend_n = 0;
    part_n = 0;
    @(posedge clk_i);
    alg_i <= g;
    low_lim_i <= lo;
    high_lim_i <= hi;
    halt_at_end_i <= h;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    repeat (2000) begin
      @(negedge clk_i);
      if (done_o === 1'b1 || halted_o === 1'b1 || pend_n > 1) break;
    end
    // a run that never ends counts as a mismatch
    if (done_o !== 1'b1 && halted_o !== 1'b1 && pend_n < 2) begin
      error_cnt++;
      $display("ERROR run end expected done seen timeout");
    end
    build(g, lo, hi);
  endtask : run
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_up();
    run(ALG_UP, 16'h0010, 16'h0017, 1'b1);
    chk_log();
    chk_bit("done", 1'b1, done_o);
    $display("test up finished");
  endtask : t_up
  task automatic t_up_fault();
    {flip_addr, flip_en, lat} <= {16'h0013, 1'b1, 2'h2};
    run(ALG_UP, 16'h0010, 16'h0017, 1'b1);
    repeat (20) @(negedge clk_i);
    chk_word("accesses before halt", 33'd13, 33'(log_q.size()));
    chk_bit("halted", 1'b1, halted_o);
    chk_word("err addr", 33'h13, 33'(err_addr_o));
    chk_word("err data", 33'h12, 33'(err_data_o));
    chk_word("err exp", 33'h13, 33'(err_exp_o));
    chk_bit("err", 1'b1, err_o);
    $display("test up fault finished");
  endtask : t_up_fault
  task automatic t_down_nodual();
    {flip_en, lat} <= {1'b0, 2'h1};
    run(ALG_DOWN, 16'h005e, 16'h0067, 1'b1);
    chk_log();
    lat <= 2'h3;
    run(ALG_NODUAL, 16'h0020, 16'h0022, 1'b1);
    chk_log();
    chk_word("second part accesses", 33'd21, 33'(part_n));
    chk_bit("err", 1'b0, err_o);
    $display("test down and no-dual finished");
  endtask : t_down_nodual
  task automatic t_pattern_noise();
    {flip_addr, flip_en, lat} <= {16'h0041, 1'b1, 2'h0};
    run(ALG_PATTERN, 16'h0040, 16'h0043, 1'b1);
    chk_log();
    chk_word("pattern errors", 33'd6, 33'(evt_n));
    chk_word("err data", 33'h3332, 33'(err_data_o));
    chk_bit("done", 1'b1, done_o);
    flip_addr <= 16'h0201;
    run(ALG_NOISE, 16'h01fc, 16'h0203, 1'b1);
    chk_log();
    chk_word("second part accesses", 33'd40, 33'(part_n));
    chk_word("noise errors", 33'd2, 33'(evt_n));
    chk_word("err exp", 33'h0, 33'(err_exp_o));
    chk_word("err data", 33'h1, 33'(err_data_o));
    $display("test pattern and noise finished");
  endtask : t_pattern_noise
  task automatic t_restart_loop();
    flip_en <= 1'b0;
    run(ALG_UP, 16'h0010, 16'h0013, 1'b1);
    chk_bit("err cleared", 1'b0, err_o);
    run(ALG_UP, 16'h0020, 16'h001f, 1'b1);
    chk_word("empty zone", 33'd0, 33'(log_q.size()));
    chk_bit("empty done", 1'b1, done_o);
    run(ALG_UP, 16'h0010, 16'h0011, 1'b0);
    chk_bit("passes repeat", 1'b1, pend_n > 1);
    chk_bit("not done", 1'b0, done_o);
    $display("test restart and loop finished");
  endtask : t_restart_loop
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_up();
    t_up_fault();
    t_down_nodual();
    t_pattern_noise();
    t_restart_loop();
    wrap_up();
  end
  // hang guard: all runs together need well under 1 ms
  initial begin
    #1ms;
    error_cnt++;
    $display("ERROR watchdog expected finish seen hang");
    wrap_up();
  end
endmodule : tb_core_memory_pattern_tester
bind cmpt_top cmpt_chk u_chk (.clk_i, .rst_i, .start_i, .alg_i, .low_lim_i, .high_lim_i, .mem_req_o, .mem_we_o,
  .mem_addr_o, .mem_wdata_o, .mem_ack_i, .mem_rdata_i, .busy_o, .done_o, .halted_o, .err_o, .err_evt_o,
  .err_addr_o, .err_data_o, .pass_end_o);
